// >>> core/lstc_trigger.sv
// Contract
// [R01] Pulses under 1 us are ignored
// [R02] Strobe width follows the line start shutter
// [R03] Trigger mode off: internal free run
// [R04] Free run uses programmed rate below maximum
// [R05] Free run clamps to the maximum rate
// [R06] Each recognised trigger starts one line; with the rescaler on, lines are paced from resc_period instead
// [R07] Host supplies one trigger per line
// [R08] External source uses the trigger pin
// [R09] CC1 source uses the CC1 line
// [R10] Activation picks rising, falling or both
// [R11] Triggered mode: rate follows input period
// [R12] Host keeps trigger rate under maximum
// [R13] Rescaler enable: 0 off, 1 on
// [R14] Rate factor 0.01 to 100, six decimals
// [R15] Filter codes 0-5 select 16 to 512
// [R16] Output frequency is input times factor
// [R17] Free run ignores both trigger inputs
`timescale 1ns/1ns
`default_nettype none

module lstc_trigger
(
  input wire logic clk,
  input wire logic reset,
  input wire lstc_pkg::lstc_cfg_t cfg,
  input wire logic trig_in,
  input wire logic cc1_in,
  output lstc_pkg::lstc_out_t out
);
  import lstc_pkg::*;

  typedef struct packed {
    logic ext_prev;
    logic cc1_prev;
    logic [PER_W-1:0] pace_cnt;
    logic [PER_W-1:0] meas_cnt;
    logic meas_ok;
    logic avg_ok;
    logic [AVG_W-1:0] avg;
    logic div_busy;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic [NUM_W-1:0] div_num;
    logic [RATE_W:0] div_rem;
    logic [PER_W-1:0] resc_period;
    logic resc_ok;
    logic [PER_W-1:0] sh_cnt;
    logic line_start;
    logic strobe;
  } lstc_state_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Longer period is the slower rate; never below one cycle
  function automatic logic [PER_W-1:0] slow_period(input logic [PER_W-1:0] want,
                                                   input logic [PER_W-1:0] floor_p);
    logic [PER_W-1:0] p;
    p = (want < floor_p) ? floor_p : want;
    return (p == PER_RST) ? 24'h00_0001 : p;
  endfunction : slow_period

  function automatic logic edge_hit(input lstc_act_t act, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (act)
      LSTC_ACT_RISE: return rise;
      LSTC_ACT_FALL: return fall;
      LSTC_ACT_BOTH: return rise | fall;
      default: return 1'b0;
    endcase
  endfunction : edge_hit

  // ----------------------------------------
  // Input width filters
  // ----------------------------------------
  logic ext_lvl;
  logic cc1_lvl;

  lstc_width_filter u_ext_filter
  (
    .clk(clk),
    .reset(reset),
    .raw(trig_in),
    .level(ext_lvl)
  );

  lstc_width_filter u_cc1_filter
  (
    .clk(clk),
    .reset(reset),
    .raw(cc1_in),
    .level(cc1_lvl)
  );

  // ----------------------------------------
  // Line start logic
  // ----------------------------------------
  lstc_state_t s_q, s_d;

  always_comb
  begin
    logic ext_edge;
    logic cc1_edge;
    logic in_trig;
    logic resc_mode;
    logic pace_on;
    logic fire;
    logic [PER_W-1:0] pace_per;
    logic [RATE_W-1:0] rate;
    logic [3:0] shift;
    logic signed [AVG_W+1:0] diff;
    logic signed [AVG_W+1:0] step;
    logic [RATE_W:0] rem_sh;
    ext_edge = 1'b0;
    cc1_edge = 1'b0;
    in_trig = 1'b0;
    resc_mode = 1'b0;
    pace_on = 1'b0;
    fire = 1'b0;
    pace_per = PER_RST;
    rate = RATE_ONE;
    shift = 4'h0;
    diff = '0;
    step = '0;
    rem_sh = REM_RST;
    s_d = s_q;
    s_d.ext_prev = ext_lvl;
    s_d.cc1_prev = cc1_lvl;

    ext_edge = edge_hit(cfg.activation, s_q.ext_prev, ext_lvl); // [R10]
    cc1_edge = edge_hit(cfg.activation, s_q.cc1_prev, cc1_lvl); // [R10]
    // Edges count only in triggered mode
    if (cfg.trig_mode) // [R17]
    begin
      in_trig = (cfg.source == LSTC_SRC_CC1) ? cc1_edge : ext_edge; // [R08] [R09]
    end
    resc_mode = cfg.trig_mode & cfg.resc_en; // [R13]

    // Input period measurement with exponential averaging
    if (resc_mode)
    begin
      if (s_q.meas_cnt != PER_SAT)
      begin
        s_d.meas_cnt = s_q.meas_cnt + 24'h00_0001;
      end
      if (in_trig)
      begin
        s_d.meas_cnt = 24'h00_0001;
        s_d.meas_ok = 1'b1;
        if (s_q.meas_ok && !s_q.avg_ok)
        begin
          s_d.avg = {s_q.meas_cnt, 9'h000};
          s_d.avg_ok = 1'b1;
        end
        else if (s_q.meas_ok)
        begin
          shift = (cfg.resc_filter > FILT_CODE_MAX) ? 4'(FILT_CODE_MAX) : 4'(cfg.resc_filter);
          shift = shift + 4'(FILT_SHIFT_BASE); // [R15]
          diff = $signed({2'b00, s_q.meas_cnt, 9'h000}) - $signed({2'b00, s_q.avg});
          step = diff >>> shift; // [R15]
          s_d.avg = s_q.avg + step[AVG_W-1:0];
        end
      end
    end
    else
    begin
      s_d.meas_cnt = PER_RST;
      s_d.meas_ok = 1'b0;
      s_d.avg_ok = 1'b0;
      s_d.resc_ok = 1'b0;
    end

    // Out period = avg period / factor, by restoring division
    rate = cfg.resc_rate;
    if (rate < RATE_MIN) // [R14]
    begin
      rate = RATE_MIN;
    end
    else if (rate > RATE_MAX)
    begin
      rate = RATE_MAX;
    end
    if (!s_q.div_busy)
    begin
      s_d.div_busy = s_q.avg_ok;
      s_d.div_cnt = DIV_STEPS;
      s_d.div_rem = REM_RST;
      s_d.div_num = NUM_W'(s_q.avg[AVG_W-1:FRAC_W]) * NUM_W'(RATE_ONE); // [R16]
    end
    else
    begin
      rem_sh = {s_q.div_rem[RATE_W-1:0], s_q.div_num[NUM_W-1]};
      s_d.div_num = {s_q.div_num[NUM_W-2:0], 1'b0};
      s_d.div_rem = rem_sh;
      if (rem_sh >= {1'b0, rate})
      begin
        s_d.div_rem = rem_sh - {1'b0, rate};
        s_d.div_num[0] = 1'b1;
      end
      s_d.div_cnt = s_q.div_cnt - 6'h01;
      if (s_q.div_cnt == 6'h01)
      begin
        s_d.div_busy = 1'b0;
        if (resc_mode)
        begin
          s_d.resc_ok = 1'b1;
          s_d.resc_period = (s_d.div_num[NUM_W-1:PER_W] != '0) ? PER_SAT :
                            s_d.div_num[PER_W-1:0]; // [R16]
        end
      end
    end

    // Pacing: free run or rescaled trigger stream
    if (!cfg.trig_mode) // [R03]
    begin
      pace_on = 1'b1;
      pace_per = slow_period(cfg.line_period, cfg.min_period); // [R04] [R05]
    end
    else if (resc_mode && s_q.resc_ok)
    begin
      pace_on = 1'b1;
      pace_per = slow_period(s_q.resc_period, cfg.min_period);
    end
    if (pace_on)
    begin
      if (s_q.pace_cnt + 24'h00_0001 >= pace_per)
      begin
        fire = 1'b1;
        s_d.pace_cnt = PER_RST;
      end
      else
      begin
        s_d.pace_cnt = s_q.pace_cnt + 24'h00_0001;
      end
    end
    else
    begin
      s_d.pace_cnt = PER_RST;
      // Direct triggering: the input edge itself paces the lines
      fire = in_trig & ~resc_mode; // [R11]
    end

    // One line start per fire, from pacing or a direct trigger; shutter and strobe share the width
    s_d.line_start = fire; // [R06]
    if (fire)
    begin
      s_d.sh_cnt = (cfg.exposure == PER_RST) ? 24'h00_0001 : cfg.exposure;
    end
    else if (s_q.sh_cnt != PER_RST)
    begin
      s_d.sh_cnt = s_q.sh_cnt - 24'h00_0001;
    end
    s_d.strobe = (s_d.sh_cnt != PER_RST); // [R02]
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // One driver for the whole output struct
  assign out = '{line_start: s_q.line_start,
                 strobe: s_q.strobe,
                 resc_valid: s_q.resc_ok,
                 resc_period: s_q.resc_period};

endmodule : lstc_trigger

`default_nettype wire

// >>> core/lstc_width_filter.sv
`timescale 1ns/1ns
`default_nettype none

module lstc_width_filter
(
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  output logic level
);
  import lstc_pkg::*;

  typedef struct packed {
    logic lvl;
    logic [FLT_CNT_W-1:0] cnt;
  } lstc_flt_state_t;

  lstc_flt_state_t s_q, s_d;

  // A new level is taken only after it has stood for the least width
  always_comb
  begin
    s_d = s_q;
    if (raw != s_q.lvl)
    begin
      if (32'(s_q.cnt) + 32'd1 >= MIN_TRIG_CYC) // [R01]
      begin
        s_d.lvl = raw;
        s_d.cnt = FLT_CNT_RST;
      end
      else
      begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
    end
    else
    begin
      s_d.cnt = FLT_CNT_RST;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;

endmodule : lstc_width_filter

`default_nettype wire

// >>> pkg/lstc_pkg.sv
`default_nettype none
package lstc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MIN_TRIG_WIDTH_NS = 1000;
  // Least width rounds up to whole cycles
  localparam int unsigned MIN_TRIG_CYC =
    (MIN_TRIG_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FLT_CNT_W = 5;

  // ----------------------------------------
  // Widths and scaling
  // ----------------------------------------
  localparam int unsigned PER_W = 24;
  localparam int unsigned RATE_W = 27;
  localparam int unsigned FRAC_W = 9;
  localparam int unsigned AVG_W = PER_W + FRAC_W;
  localparam int unsigned NUM_W = 44;
  localparam int unsigned DIV_CNT_W = 6;
  // Rate factor is in millionths: 1.000000 is 1_000_000
  localparam logic [RATE_W-1:0] RATE_ONE = 27'h00F_4240;
  localparam logic [RATE_W-1:0] RATE_MIN = 27'h000_2710;
  localparam logic [RATE_W-1:0] RATE_MAX = 27'h5F5_E100;
  localparam logic [DIV_CNT_W-1:0] DIV_STEPS = 6'h2C;
  localparam logic [2:0] FILT_CODE_MAX = 3'h5;
  localparam int unsigned FILT_SHIFT_BASE = 4;
  localparam logic [PER_W-1:0] PER_SAT = 24'hFF_FFFF;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PER_W-1:0] PER_RST = 24'h00_0000;
  localparam logic [AVG_W-1:0] AVG_RST = 33'h0_0000_0000;
  localparam logic [NUM_W-1:0] NUM_RST = 44'h000_0000_0000;
  localparam logic [RATE_W:0] REM_RST = 28'h000_0000;
  localparam logic [FLT_CNT_W-1:0] FLT_CNT_RST = 5'h00;
  localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST = 6'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {LSTC_SRC_EXT, LSTC_SRC_CC1} lstc_src_t;
  typedef enum logic [1:0] {LSTC_ACT_RISE, LSTC_ACT_FALL, LSTC_ACT_BOTH} lstc_act_t;

  typedef struct packed {
    logic trig_mode;
    lstc_src_t source;
    lstc_act_t activation;
    logic resc_en;
    logic [2:0] resc_filter;
    logic [RATE_W-1:0] resc_rate;
    logic [PER_W-1:0] line_period;
    logic [PER_W-1:0] min_period;
    logic [PER_W-1:0] exposure;
  } lstc_cfg_t;

  typedef struct packed {
    logic line_start;
    logic strobe;
    logic resc_valid;
    logic [PER_W-1:0] resc_period;
  } lstc_out_t;

endpackage : lstc_pkg

`default_nettype wire

// >>> sim/lstc_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module lstc_src_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic en,
  input wire lstc_pkg::lstc_src_t sel,
  input wire logic [15:0] per,
  input wire logic [15:0] wid,
  output logic trig_in,
  output logic cc1_in
);
  import lstc_pkg::*;
  logic [15:0] cnt_q;
  logic lvl;
  // One pulse per period; the bench keeps the period above the line limit
  assign lvl = en && cnt_q < wid;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      trig_in <= 1'b0;
      cc1_in <= 1'b0;
    end
    else
    begin
      cnt_q <= (!en || cnt_q == per - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      trig_in <= lvl && sel == LSTC_SRC_EXT;
      cc1_in <= lvl && sel == LSTC_SRC_CC1;
    end
  end
endmodule : lstc_src_model
`default_nettype wire

// >>> sim/lstc_trigger_chk.sv
`timescale 1ns/1ns
`default_nettype none
module lstc_chk
(
  input wire logic clk,
  input wire logic reset,
  input wire lstc_pkg::lstc_cfg_t cfg,
  input wire logic trig_in,
  input wire logic cc1_in,
  input wire lstc_pkg::lstc_out_t out
);
  import lstc_pkg::*;
  // ----
  // Helpers
  // ----
  logic [PER_W-1:0] gap_q;
  logic [PER_W-1:0] st_q;
  logic [5:0] qt_q;
  logic arm_q;
  logic fr;
  lstc_cfg_t cfg_q;
  logic [1:0] in_q;
  // Pace is judged only when free run held the same settings since the last line
  assign fr = arm_q && cfg == cfg_q && out.line_start;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gap_q <= '0;
      st_q <= '0;
      qt_q <= '0;
      arm_q <= 1'b0;
      cfg_q <= '0;
      in_q <= '0;
    end
    else
    begin
      cfg_q <= cfg;
      in_q <= {trig_in, cc1_in};
      gap_q <= out.line_start ? 24'h00_0001 : gap_q + 24'h00_0001;
      st_q <= out.line_start ? 24'h00_0001 : st_q + 24'h00_0001;
      qt_q <= ({trig_in, cc1_in} != in_q) ? 6'h00 : qt_q + {5'h00, qt_q != 6'h3F};
      arm_q <= (cfg != cfg_q) ? 1'b0 : out.line_start ? !cfg.trig_mode : arm_q;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_one;
    out.line_start && cfg.min_period > 24'h00_0001 |=> !out.line_start;
  endproperty
  a_one: assert property (p_one) else $error("line start too long");
  property p_srise;
    $rose(out.strobe) |-> out.line_start;
  endproperty
  a_srise: assert property (p_srise) else $error("strobe rose alone");
  property p_son;
    out.line_start |-> out.strobe;
  endproperty
  a_son: assert property (p_son) else $error("strobe low at line start");
  property p_swid;
    $fell(out.strobe) && cfg.exposure != 24'h00_0000 |-> st_q == cfg.exposure;
  endproperty
  a_swid: assert property (p_swid) else $error("strobe width wrong");
  property p_prog;
    fr && cfg.line_period >= cfg.min_period |-> gap_q == cfg.line_period;
  endproperty
  a_prog: assert property (p_prog) else $error("free run period wrong");
  property p_clamp;
    fr && cfg.line_period < cfg.min_period |-> gap_q == cfg.min_period;
  endproperty
  a_clamp: assert property (p_clamp) else $error("free run clamp wrong");
  property p_quiet;
    cfg.trig_mode && !cfg.resc_en && qt_q == 6'h3F |-> !out.line_start;
  endproperty
  a_quiet: assert property (p_quiet) else $error("line without input edge");
  property p_rvld;
    $rose(out.resc_valid) |-> cfg.resc_en && cfg.trig_mode;
  endproperty
  a_rvld: assert property (p_rvld) else $error("rescaler active while off");
endmodule : lstc_chk
bind lstc_trigger lstc_chk lstc_chk_inst (.clk(clk), .reset(reset), .cfg(cfg),
  .trig_in(trig_in), .cc1_in(cc1_in), .out(out));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0d got %0d", n, e, g); end end
module tb;
  import lstc_pkg::*;
  logic clk, reset, en, trig_in, cc1_in;
  lstc_src_t sel;
  logic [15:0] per, wid;
  lstc_cfg_t cfg;
  lstc_out_t out;
  int fails, checked, cyc, ls_n, n0, g;
  lstc_trigger lstc_trigger_inst (.clk(clk), .reset(reset), .cfg(cfg),
    .trig_in(trig_in), .cc1_in(cc1_in), .out(out));
  lstc_src_model lstc_src_model_inst (.clk(clk), .reset(reset), .en(en), .sel(sel),
    .per(per), .wid(wid), .trig_in(trig_in), .cc1_in(cc1_in));
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report;
    end
  end
  // Line starts are counted mid-cycle, where the output has settled
  always @(negedge clk)
  begin
    if (out.line_start === 1'b1) ls_n++;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Cycles up to the next line start, at least one
  task wls(output int c);
    c = 0;
    do
    begin
      step(1);
      c++;
    end while (out.line_start !== 1'b1 && c < 5000);
  endtask : wls
  task gap(input int e, input string nm);
    int c;
    wls(c);
    wls(c);
    `CHK(nm, e, c)
  endtask : gap
  task pulse(input logic [15:0] w);
    en = 1;
    per = 16'hFFFF;
    wid = w;
    step(w);
    en = 0;
    step(70);
  endtask : pulse
  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial
  begin
    reset = 1;
    en = 0;
    sel = LSTC_SRC_EXT;
    per = 16'h0000;
    wid = 16'h0000;
    cfg = '0;
    cfg.line_period = 24'h00_0028;
    cfg.min_period = 24'h00_0014;
    cfg.exposure = 24'h00_0005;
    step(3);
    reset = 0;
    // Trigger pin toggles during free run and must not disturb pacing
    en = 1;
    per = 16'h003C;
    wid = 16'h001E;
    gap(40, "rate");
    wls(g);
    g = 0;
    while (out.strobe === 1'b1 && g < 100)
    begin
      step(1);
      g++;
    end
    `CHK("strobe", 5, g)
    cfg.line_period = 24'h00_000A;
    cfg.min_period = 24'h00_0032;
    gap(50, "clamp");
    en = 0;
    $display("test free run done");
    cfg.trig_mode = 1;
    cfg.min_period = 24'h00_0014;
    step(100);
    for (int s = 0; s < 2; s++)
      for (int a = 0; a < 3; a++)
      begin
        cfg.source = lstc_src_t'(s);
        cfg.activation = lstc_act_t'(a);
        sel = cfg.source;
        n0 = ls_n;
        pulse(16'h0028);
        `CHK("edges", (a == 2) ? 2 : 1, ls_n - n0)
        sel = lstc_src_t'(1 - s);
        n0 = ls_n;
        pulse(16'h0028);
        `CHK("unsel", 0, ls_n - n0)
      end
    sel = cfg.source;
    n0 = ls_n;
    pulse(16'h0018);
    `CHK("short", 0, ls_n - n0)
    pulse(16'h0019);
    `CHK("wide", 2, ls_n - n0)
    cfg.activation = LSTC_ACT_RISE;
    en = 1;
    per = 16'h0064;
    wid = 16'h0032;
    gap(100, "period");
    en = 0;
    $display("test direct trigger done");
    step(100);
    cfg.source = LSTC_SRC_EXT;
    sel = LSTC_SRC_EXT;
    cfg.resc_en = 1;
    cfg.resc_rate = 27'h01E_8480;
    en = 1;
    per = 16'h0190;
    wid = 16'h0064;
    step(1500);
    `CHK("valid", 1'b1, out.resc_valid)
    `CHK("rper", 24'h00_00C8, out.resc_period)
    gap(200, "rgap");
    cfg.resc_rate = 27'h007_A120;
    cfg.resc_filter = 3'h5;
    step(200);
    `CHK("rper", 24'h00_0320, out.resc_period)
    gap(800, "rgap");
    // One input period of 560 after steady 400 moves the average by 1/16 of the step
    cfg.resc_filter = 3'h0;
    while (trig_in === 1'b1) step(1);
    while (trig_in !== 1'b1) step(1);
    per = 16'h0230;
    while (trig_in === 1'b1) step(1);
    while (trig_in !== 1'b1) step(1);
    step(150);
    `CHK("rfilt", 24'h00_0334, out.resc_period)
    $display("test rescaler done");
    final_report;
  end
endmodule : tb
`default_nettype wire
